//--- rtl/quad_enc_out.sv
// Quadrature encoder output generator with marker and edge-rate limiting
`timescale 1ns/1ps
`default_nettype none
module quad_enc_out
   import quad_enc_pkg::*;
#(
   parameter logic [MARK_W-1:0] MARK_W0 = MARK_WIDTH_0,
   parameter logic [MARK_W-1:0] MARK_W1 = MARK_WIDTH_1,
   parameter logic [MARK_W-1:0] MARK_W2 = MARK_WIDTH_2,
   parameter logic [MARK_W-1:0] MARK_W3 = MARK_WIDTH_3
)(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [quad_enc_pkg::ANGLE_W-1:0] angle,
   input wire logic angle_valid,
   input wire quad_enc_pkg::enc_cfg_t cfg,
   input wire logic warn_clear,
   output quad_enc_pkg::enc_out_t enc_out,
   output logic step_limit_warning
);
   import quad_enc_pkg::*;

   logic [ANGLE_W-1:0] tgt_pos, tgt_mask;
   logic [ANGLE_W-1:0] pos_ff, nxt_pos;
   logic [ANGLE_W-1:0] goal_ff, nxt_goal;
   logic [ANGLE_W-1:0] diff;
   logic synced_ff, nxt_synced;
   logic limit_on, space_ok, step, step_up, step_dn, delayed;
   logic warn_ff, nxt_warn;
   logic [MARK_W-1:0] mark_cnt_ff, nxt_mark_cnt;
   logic [MARK_W-1:0] mark_len;
   logic mark_dir_ff, nxt_mark_dir;
   quad_state_t qs;
   enc_out_t out_ff, nxt_out;

   // Angle scaled to quadrature steps, direction applied
   quad_pos_calc u_calc (
      .angle(angle),
      .resolution(cfg.resolution),
      .rotation_reverse(cfg.rotation_reverse),
      .qpos(tgt_pos),
      .qmask(tgt_mask)
   );

   edge_spacer u_space (
      .clk(clk),
      .rst_n(rst_n),
      .limit(cfg.step_limit),
      .step(step),
      .ready(space_ok)
   );

   // Step position toward goal, one state at a time; the first valid angle after reset loads it directly
   always_comb begin
      limit_on = (cfg.step_limit != '0);
      nxt_goal = goal_ff;
      nxt_synced = synced_ff;
      if (angle_valid) begin
         nxt_goal = tgt_pos;
      end
      // Forward distance within one revolution decides direction
      diff = (goal_ff - pos_ff) & tgt_mask;
      step_up = 1'b0;
      step_dn = 1'b0;
      delayed = 1'b0;
      if (!synced_ff) begin
         nxt_synced = angle_valid;
      end else if (diff != '0) begin
         if (!limit_on) begin
            // Without limiting, jump along still one state per clock
            step_up = ~diff[ANGLE_W-1] & (diff <= (tgt_mask >> 1));
            step_dn = ~step_up;
         end else if (space_ok) begin
            step_up = (diff <= (tgt_mask >> 1));
            step_dn = ~step_up;
         end
         // Pending steps beyond one, or held by spacing, are delays
         delayed = limit_on & (!space_ok | ((diff != 15'h0001) & (diff != tgt_mask)));
      end
      step = step_up | step_dn;
      nxt_pos = pos_ff;
      if (!synced_ff && angle_valid) begin
         nxt_pos = tgt_pos;
      end else if (step_up) begin
         nxt_pos = (pos_ff + 1'b1) & tgt_mask;
      end else if (step_dn) begin
         nxt_pos = (pos_ff - 1'b1) & tgt_mask;
      end
      if (nxt_pos > tgt_mask) begin
         nxt_pos = nxt_pos & tgt_mask;
      end
   end

   // Marker length scales with resolution: counts in quadrature states
   always_comb begin
      case (cfg.marker_mode)
         2'h0: mark_len = MARK_W0;
         2'h1: mark_len = MARK_W1;
         2'h2: mark_len = MARK_W2;
         2'h3: mark_len = MARK_W3;
         default: mark_len = MARK_W0;
      endcase
      // Marker never wider than a revolution, so coarse settings clip
      if (ANGLE_W'(mark_len) > tgt_mask) begin
         mark_len = MARK_W'(tgt_mask);
      end
   end

   // Marker: high while position in [0, len) states
   always_comb begin
      nxt_mark_cnt = mark_cnt_ff;
      nxt_mark_dir = mark_dir_ff;
      if (step_up) begin
         nxt_mark_dir = 1'b0;
      end else if (step_dn) begin
         nxt_mark_dir = 1'b1;
      end
      // Rising edge at zero going up; falling edge at zero going down
      if (nxt_pos < ANGLE_W'(mark_len)) begin
         nxt_mark_cnt = MARK_W'(nxt_pos) + 1'b1;
      end else begin
         nxt_mark_cnt = '0;
      end
   end

   // Two low bits of position select the quadrature state
   always_comb begin
      case (pos_ff[1:0])
         2'h0: qs = quad_state_one;
         2'h1: qs = quad_state_two;
         2'h2: qs = quad_state_three;
         2'h3: qs = quad_state_four;
         default: qs = quad_state_one;
      endcase
   end

   always_comb begin
      nxt_out.phase_a = qs[1] ^ cfg.invert;
      nxt_out.phase_b = qs[0] ^ cfg.invert;
      nxt_out.marker = (mark_cnt_ff != '0) ^ cfg.invert;
      if (!synced_ff) begin
         nxt_out.phase_a = cfg.invert;
         nxt_out.phase_b = cfg.invert;
         nxt_out.marker = cfg.invert;
      end
      // Set wins over a clear in the same cycle
      nxt_warn = (warn_ff & ~warn_clear) | delayed;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pos_ff <= '0;
         goal_ff <= '0;
         synced_ff <= 1'b0;
         mark_cnt_ff <= '0;
         mark_dir_ff <= 1'b0;
         out_ff <= '0;
         warn_ff <= 1'b0;
      end else begin
         pos_ff <= nxt_pos;
         goal_ff <= nxt_goal;
         synced_ff <= nxt_synced;
         mark_cnt_ff <= nxt_mark_cnt;
         mark_dir_ff <= nxt_mark_dir;
         out_ff <= nxt_out;
         warn_ff <= nxt_warn;
      end
   end

   always_comb begin
      enc_out = out_ff;
      step_limit_warning = warn_ff;
   end
endmodule
`default_nettype wire

//--- rtl/quad_enc_pkg.sv
// Package of constants and types for the quadrature encoder output block
package quad_enc_pkg;
   localparam int ANGLE_W = 15;
   localparam int RES_W = 4;
   localparam logic [3:0] RES_CODE_MIN = 4'h3;
   localparam logic [3:0] RES_CODE_MAX = 4'hE;
   localparam int RES_N_AT_MIN = 11;
   localparam int LIMIT_W = 16;
   localparam int SAMPLE_PERIOD_NS = 1000;
   localparam int CLK_PERIOD_NS = 5;
   localparam int SAMPLE_CYCLES = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int MARK_W = 8;
   localparam logic [7:0] MARK_WIDTH_0 = 8'h01;
   localparam logic [7:0] MARK_WIDTH_1 = 8'h02;
   localparam logic [7:0] MARK_WIDTH_2 = 8'h03;
   localparam logic [7:0] MARK_WIDTH_3 = 8'h04;
   localparam logic [1:0] QUAD_RESET = 2'h0;

   typedef enum logic [1:0] {
      quad_state_one = 2'b00,
      quad_state_two = 2'b01,
      quad_state_three = 2'b11,
      quad_state_four = 2'b10
   } quad_state_t;

   typedef struct packed {
      logic [3:0] resolution;
      logic [1:0] marker_mode;
      logic invert;
      logic rotation_reverse;
      logic [15:0] step_limit;
   } enc_cfg_t;

   typedef struct packed {
      logic phase_a;
      logic phase_b;
      logic marker;
   } enc_out_t;
endpackage

//--- rtl/quad_pos_calc.sv
// Angle to target quadrature position conversion
`timescale 1ns/1ps
`default_nettype none
module quad_pos_calc
   import quad_enc_pkg::*;
(
   input wire logic [ANGLE_W-1:0] angle,
   input wire logic [RES_W-1:0] resolution,
   input wire logic rotation_reverse,
   output logic [ANGLE_W-1:0] qpos,
   output logic [ANGLE_W-1:0] qmask
);
   logic [ANGLE_W-1:0] ang_dir;
   logic [3:0] shift;
   always_comb begin
      ang_dir = rotation_reverse ? ANGLE_W'(~angle + 1'b1) : angle;
      // Unused codes clamp to the nearest end: codes below the range to the finest setting, codes above it to the coarsest
      if (resolution < RES_CODE_MIN) begin
         shift = 4'(ANGLE_W - 2 - RES_N_AT_MIN);
      end else if (resolution > RES_CODE_MAX) begin
         shift = 4'(ANGLE_W - 2);
      end else begin
         shift = 4'(ANGLE_W - 2 - RES_N_AT_MIN) + 4'(resolution - RES_CODE_MIN);
      end
      qpos = ang_dir >> shift;
      qmask = {ANGLE_W{1'b1}} >> shift;
   end
endmodule
`default_nettype wire

//--- rtl/edge_spacer.sv
// Minimum spacing counter between output edges
`timescale 1ns/1ps
`default_nettype none
module edge_spacer
   import quad_enc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic [LIMIT_W-1:0] limit,
   input wire logic step,
   output logic ready
);
   logic [LIMIT_W-1:0] cnt_ff, nxt_cnt;
   always_comb begin
      nxt_cnt = cnt_ff;
      if (step) begin
         nxt_cnt = limit;
      end else if (cnt_ff != '0) begin
         nxt_cnt = cnt_ff - 1'b1;
      end
      ready = (cnt_ff <= 16'h0001);
   end
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_ff <= '0;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end
endmodule
`default_nettype wire

//--- tb/quad_enc_props.sv
// Assertion checker for the encoder output block
`timescale 1ns/1ps
`default_nettype none
module quad_enc_props
   import quad_enc_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire quad_enc_pkg::enc_cfg_t cfg,
   input wire logic warn_clear,
   input wire quad_enc_pkg::enc_out_t enc_out,
   input wire logic step_limit_warning
);
   logic [1:0] ab_ff;
   logic [2:0] qc_ff;
   logic [15:0] gap_ff;
   logic [1:0] ab;
   logic chg, quiet, seen;
   always_comb begin
      ab = {enc_out.phase_a, enc_out.phase_b};
      chg = ab != ab_ff;
      quiet = qc_ff == 3'h4;
      seen = gap_ff != 16'hFFFF;
   end
   // Config edits get a few cycles to settle before outputs are judged
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ab_ff <= 2'h0;
         qc_ff <= 3'h0;
         gap_ff <= 16'hFFFF;
      end else begin
         ab_ff <= ab;
         qc_ff <= $changed(cfg) ? 3'h0 : qc_ff + {2'h0, !quiet};
         gap_ff <= chg ? 16'h0001 : gap_ff + {15'h0, seen};
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   AST_GRAY: assert property (seen && quiet |-> (ab ^ ab_ff) != 2'h3)
      else $error("two phases moved");
   AST_SPACE: assert property (seen && quiet && chg && cfg.step_limit != 16'h0
      |-> gap_ff >= cfg.step_limit) else $error("edges too close");
   AST_MARK: assert property (seen && quiet && $changed(enc_out.marker) |-> chg)
      else $error("marker moved alone");
   AST_MZERO: assert property (quiet && cfg.marker_mode == 2'h0 && !cfg.invert
      && enc_out.marker |-> ab == 2'h0) else $error("marker off zero");
   AST_WSRC: assert property ($rose(step_limit_warning) |-> $past(cfg.step_limit) != 16'h0)
      else $error("warning unlimited");
   AST_WHOLD: assert property (step_limit_warning && !warn_clear |=> step_limit_warning)
      else $error("warning dropped");
   AST_WCLR: assert property ((warn_clear && cfg.step_limit == 16'h0) [*2]
      |=> !step_limit_warning) else $error("warning kept");
   AST_RST: assert property ($past(rst_n) && !$past(rst_n, 2)
      |-> enc_out == {3{cfg.invert}}) else $error("idle level wrong");
endmodule
bind quad_enc_out quad_enc_props i_quad_enc_props (.clk, .rst_n, .cfg, .warn_clear,
   .enc_out, .step_limit_warning);
`default_nettype wire

//--- tb/quad_rx_model.sv
// Host receiver model counting quadrature steps
`timescale 1ns/1ps
`default_nettype none
module quad_rx_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic a,
   input wire logic b,
   output logic [1:0] pos,
   output logic err
);
   logic [1:0] idx_ff;
   logic [1:0] dif;
   assign dif = {a, a ^ b} - idx_ff;
   // Two-bit count wraps once a turn at the coarsest resolution only
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         idx_ff <= 2'h0;
         pos <= 2'h0;
         err <= 1'b0;
      end else begin
         idx_ff <= {a, a ^ b};
         if (dif == 2'h1) begin
            pos <= pos + 2'h1;
         end else if (dif == 2'h3) begin
            pos <= pos - 2'h1;
         end
         err <= err | (dif == 2'h2);
      end
   end
endmodule
`default_nettype wire

//--- tb/tb_top.sv
// Bench for the encoder output block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import quad_enc_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [14:0] angle = 15'h0;
   logic angle_valid = 1'b0;
   enc_cfg_t cfg = '{4'hE, 2'h0, 1'b0, 1'b0, 16'h0};
   logic warn_clear = 1'b0;
   enc_out_t enc_out;
   logic step_limit_warning, rx_err;
   logic [1:0] rx_pos;
   int bad_count = 0;
   int samples_checked = 0;
   int k;
   logic [14:0] ang [8] = '{15'h0, 15'h2000, 15'h4000, 15'h6000,
      15'h0, 15'h6000, 15'h4000, 15'h2000};
   logic [2:0] want [8] = '{3'h1, 3'h2, 3'h6, 3'h4, 3'h1, 3'h4, 3'h6, 3'h2};
   logic [7:0] mw [4] = '{MARK_WIDTH_0, MARK_WIDTH_1, MARK_WIDTH_2, MARK_WIDTH_3};
   always #2.5 clk = ~clk;
   quad_enc_out i_quad_enc_out (.clk, .rst_n, .angle, .angle_valid, .cfg, .warn_clear,
      .enc_out, .step_limit_warning);
   quad_rx_model i_quad_rx_model (.clk, .rst_n, .a(enc_out.phase_a ^ cfg.invert),
      .b(enc_out.phase_b ^ cfg.invert), .pos(rx_pos), .err(rx_err));
   task automatic chk(input logic [14:0] got, input logic [14:0] w);
      samples_checked++;
      if (got !== w) begin
         bad_count++;
         $display("mismatch %0t %h %h", $time, got, w);
      end
   endtask
   // Long settle covers stepping under the limit
   task automatic samp(input logic [14:0] a);
      angle <= a;
      angle_valid <= 1'b1;
      @(posedge clk);
      angle_valid <= 1'b0;
      repeat (40) @(posedge clk);
   endtask
   task automatic end_of_test();
      if (bad_count == 0 && samples_checked > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   initial begin
      repeat (4000) @(posedge clk);
      bad_count++;
      end_of_test();
   end
   initial begin
      repeat (4) @(posedge clk);
      chk(15'(enc_out), 15'h0);
      rst_n <= 1'b1;
      foreach (ang[i]) begin
         samp(ang[i]);
         chk(15'(enc_out), 15'(want[i]));
      end
      chk(15'({rx_err, rx_pos}), 15'h1);
      chk(15'(step_limit_warning), 15'h0);
      cfg.step_limit <= 16'h000A;
      samp(15'h6000);
      chk(15'(enc_out), 15'h4);
      chk(15'({rx_err, rx_pos}), 15'h3);
      chk(15'(step_limit_warning), 15'h1);
      cfg.step_limit <= 16'h0;
      warn_clear <= 1'b1;
      repeat (3) @(posedge clk);
      warn_clear <= 1'b0;
      chk(15'(step_limit_warning), 15'h0);
      // Park on the second state so only markers wider than one state show
      samp(15'h2000);
      for (int m = 0; m < 4; m++) begin
         cfg.marker_mode <= 2'(m);
         repeat (5) @(posedge clk);
         chk(15'(enc_out.marker), 15'(mw[m] > 8'h01));
      end
      cfg.invert <= 1'b1;
      repeat (5) @(posedge clk);
      chk(15'(enc_out), 15'h0004);
      for (int c = 2; c < 16; c++) begin
         k = (c < 3) ? 3 : (c > 14) ? 14 : c;
         rst_n <= 1'b0;
         cfg <= '{4'(c), 2'h0, 1'b0, 1'b0, 16'h0};
         repeat (2) @(posedge clk);
         rst_n <= 1'b1;
         samp(15'(1 << (k - 1)));
         chk(15'(enc_out), 15'h2);
         samp(15'h0);
         chk(15'(enc_out), 15'h1);
      end
      end_of_test();
   end
endmodule
`default_nettype wire
